// [logic/fcs_host.sv]
`timescale 1ns/10ps
module fcs_host import fcs_pkg::*; #(
   parameter int unsigned WINDOW_CYC = FCS_WINDOW_CYC,
   parameter int unsigned SUSPEND_CYC = FCS_SUSPEND_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire fcs_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_error,
   output fcs_mode_t mode,
   output fcs_bus_t flash_bus,
   output logic flash_reset_n,
   input wire logic [7:0] data_lines_in,
   input wire logic ready_busy_n
);

   typedef enum logic [2:0] {
      S_IDLE, S_STEP, S_BUS, S_SETTLE, S_WAIT_READY, S_SUSPEND, S_HWRST
   } fcs_state_t;

   fcs_state_t state;
   fcs_req_t cur;
   fcs_mode_t ret_mode;
   logic id_in_suspend;
   logic [2:0] step;
   logic [15:0] cnt;
   logic [15:0] win_cnt;
   logic bus_done;
   logic [7:0] bus_rdata;

   // Byte written at each step of a sequence; unlocks lead the ID, bypass entry, program and erase commands.
   function automatic logic [7:0] seq_byte(input fcs_op_t op, input logic [2:0] idx,
                                           input logic [7:0] pd);
      logic [7:0] third;
      third = (op == OP_ID_ENTER) ? FCS_CMD_ID :
              (op == OP_BYP_ENTER) ? FCS_CMD_BYPASS : FCS_CMD_PROGRAM;
      case (op)
         OP_ID_ENTER, OP_BYP_ENTER, OP_PROGRAM:
            seq_byte = (idx == 3'd0) ? FCS_UNLOCK1 : (idx == 3'd1) ? FCS_UNLOCK2 :
                       (idx == 3'd2) ? third : pd;
         OP_CHIP_ERASE, OP_SECTOR_ERASE:
            seq_byte = (idx == 3'd0 || idx == 3'd3) ? FCS_UNLOCK1 :
                       (idx == 3'd1 || idx == 3'd4) ? FCS_UNLOCK2 :
                       (idx == 3'd2) ? FCS_CMD_ERASE_SETUP :
                       (op == OP_CHIP_ERASE) ? FCS_CMD_CHIP_ERASE : FCS_CMD_SECTOR_ERASE;
         OP_BYP_PROGRAM: seq_byte = (idx == 3'd0) ? FCS_CMD_PROGRAM : pd;
         OP_BYP_EXIT: seq_byte = (idx == 3'd0) ? FCS_CMD_BYP_EXIT1 : FCS_CMD_BYP_EXIT2;
         OP_SECTOR_ADD: seq_byte = FCS_CMD_SECTOR_ERASE;
         OP_SUSPEND: seq_byte = FCS_CMD_SUSPEND;
         default: seq_byte = FCS_CMD_RESET;
      endcase
   endfunction : seq_byte

   // Index of the last bus cycle of each sequence.
   function automatic logic [2:0] seq_last(input fcs_op_t op);
      case (op)
         OP_ID_ENTER, OP_BYP_ENTER: seq_last = 3'd2;
         OP_PROGRAM: seq_last = 3'd3;
         OP_BYP_PROGRAM, OP_BYP_EXIT: seq_last = 3'd1;
         OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_last = 3'd5;
         default: seq_last = 3'd0;
      endcase
   endfunction : seq_last

   // The host refuses orders the device would ignore or that would abort it.
   function automatic logic op_legal(input fcs_op_t op, input fcs_mode_t md,
                                     input logic win_open);
      case (op)
         OP_READ: op_legal = (md == M_ARRAY || md == M_ID || md == M_SUSPENDED);
         OP_ID_ENTER, OP_PROGRAM: op_legal = (md == M_ARRAY || md == M_SUSPENDED);
         OP_RESET: op_legal = (md == M_ARRAY || md == M_ID);
         OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE: op_legal = (md == M_ARRAY);
         OP_BYP_PROGRAM, OP_BYP_EXIT: op_legal = (md == M_BYPASS);
         OP_SECTOR_ADD: op_legal = (md == M_WINDOW) && win_open;
         OP_SUSPEND: op_legal = (md == M_WINDOW || md == M_ERASING);
         default: op_legal = 1'b1;
      endcase
   endfunction : op_legal

   wire logic win_open = win_cnt < 16'(WINDOW_CYC - FCS_ADD_GUARD_CYC);
   wire logic legal = op_legal(req.op, mode, win_open);
   wire logic win_expire = (mode == M_WINDOW) && (win_cnt == 16'(WINDOW_CYC - 1));
   wire logic erase_done = (mode == M_ERASING) && (state == S_IDLE) && ready_busy_n &&
                           (win_cnt >= 16'(FCS_BUSY_DLY_CYC));
   wire logic bus_start = (state == S_STEP);
   wire logic last_step = (step == seq_last(cur.op));
   wire logic [7:0] step_data = seq_byte(cur.op, step, cur.data);
   wire logic prog_addr_step = (cur.op == OP_PROGRAM && step == 3'd3) ||
                               (cur.op == OP_BYP_PROGRAM && step == 3'd1);
   wire logic sect_addr_step = (cur.op == OP_SECTOR_ERASE && step == 3'd5) ||
                               (cur.op == OP_SECTOR_ADD);
   // Sector cycles carry only the top five bits so no stray low bits reach the device.
   wire logic [20:0] step_addr = prog_addr_step || cur.op == OP_READ ? cur.addr :
      sect_addr_step ? {cur.addr[20:FCS_SECTOR_LSB], 16'h0000} :
      (step_data == FCS_UNLOCK2) ? FCS_UNLOCK_ADDR2 : FCS_UNLOCK_ADDR1;
   // Only a hardware reset may cut into a wait for the device.
   assign req_ready = (state == S_IDLE) ||
                      (state == S_WAIT_READY && req.op == OP_HW_RESET);

   fcs_bus_cycle u_bus (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(bus_start),
      .is_read(cur.op == OP_READ),
      .addr(step_addr),
      .wdata(step_data),
      .data_in(data_lines_in),
      .done(bus_done),
      .rdata(bus_rdata),
      .bus(flash_bus)
   );

   // Window timer runs in the window and counts the busy settle in erase.
   always_ff @(posedge clk) begin
      if (sys_rst || (mode != M_WINDOW && mode != M_ERASING) || win_expire) begin
         win_cnt <= 16'h0000;
      end else if (state == S_BUS && bus_done && sect_addr_step) begin
         win_cnt <= 16'h0000;
      end else if (win_cnt != 16'hffff) begin
         win_cnt <= win_cnt + 16'h0001;
      end
   end

   // Sequencer and mode tracker; later assignments to mode override the timer ones.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= S_IDLE;
         mode <= M_ARRAY;
         ret_mode <= M_ARRAY;
         id_in_suspend <= 1'b0;
         cur <= '0;
         step <= 3'd0;
         cnt <= 16'h0000;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_error <= 1'b0;
         flash_reset_n <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         if (win_expire) begin
            mode <= M_ERASING;
         end
         if (erase_done) begin
            mode <= M_ARRAY;
         end
         unique case (state)
            S_IDLE: begin
               if (req_valid) begin
                  cur <= req;
                  step <= 3'd0;
                  rsp_error <= !legal;
                  if (!legal) begin
                     rsp_valid <= 1'b1;
                  end else if (req.op == OP_HW_RESET) begin
                     flash_reset_n <= 1'b0;
                     cnt <= 16'(FCS_RST_PULSE_CYC - 1);
                     state <= S_HWRST;
                  end else begin
                     state <= S_STEP;
                  end
               end
            end
            S_STEP: state <= S_BUS;
            S_BUS: begin
               if (bus_done && !last_step) begin
                  step <= step + 3'd1;
                  state <= S_STEP;
               end else if (bus_done) begin
                  state <= S_IDLE;
                  rsp_valid <= 1'b1;
                  rsp_data <= bus_rdata;
                  unique case (cur.op)
                     OP_ID_ENTER: begin
                        mode <= M_ID;
                        id_in_suspend <= (mode == M_SUSPENDED);
                     end
                     OP_RESET: mode <= id_in_suspend ? M_SUSPENDED : M_ARRAY;
                     OP_BYP_ENTER: mode <= M_BYPASS;
                     OP_BYP_EXIT: mode <= M_ARRAY;
                     OP_PROGRAM, OP_BYP_PROGRAM, OP_CHIP_ERASE: begin
                        rsp_valid <= 1'b0;
                        ret_mode <= (cur.op == OP_BYP_PROGRAM) ? M_BYPASS :
                                    (cur.op == OP_CHIP_ERASE) ? M_ARRAY : mode;
                        cnt <= 16'(FCS_BUSY_DLY_CYC - 1);
                        state <= S_SETTLE;
                     end
                     OP_SECTOR_ERASE, OP_SECTOR_ADD: mode <= M_WINDOW;
                     OP_SUSPEND: begin
                        if (mode == M_WINDOW && !win_expire) begin
                           mode <= M_SUSPENDED;
                        end else begin
                           rsp_valid <= 1'b0;
                           cnt <= 16'(SUSPEND_CYC - 1);
                           state <= S_SUSPEND;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            S_SETTLE: begin
               if (cnt == 16'h0000) begin
                  state <= S_WAIT_READY;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            S_WAIT_READY: begin
               if (req_valid && req.op == OP_HW_RESET) begin
                  cur <= req;
                  rsp_error <= 1'b0;
                  flash_reset_n <= 1'b0;
                  cnt <= 16'(FCS_RST_PULSE_CYC - 1);
                  state <= S_HWRST;
               end else if (ready_busy_n) begin
                  mode <= ret_mode;
                  rsp_valid <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_SUSPEND: begin
               if (ready_busy_n || cnt == 16'h0000) begin
                  mode <= M_SUSPENDED;
                  rsp_valid <= 1'b1;
                  state <= S_IDLE;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            S_HWRST: begin
               if (cnt == 16'h0000) begin
                  flash_reset_n <= 1'b1;
                  mode <= M_ARRAY;
                  id_in_suspend <= 1'b0;
                  rsp_valid <= 1'b1;
                  state <= S_IDLE;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
         endcase
      end
   end

   property p_bypass_refuse;
      @(posedge clk) disable iff (sys_rst)
      (state == S_IDLE && req_valid && mode == M_BYPASS && req.op != OP_BYP_PROGRAM &&
       req.op != OP_BYP_EXIT && req.op != OP_HW_RESET) |=> (rsp_valid && rsp_error);
   endproperty
   a_bypass_refuse: assert property (p_bypass_refuse) else $error("fast mode took a command");

   property p_id_exit;
      @(posedge clk) disable iff (sys_rst)
      (state == S_IDLE && req_valid && mode == M_ID && req.op == OP_PROGRAM)
         |=> (rsp_valid && rsp_error && mode == M_ID);
   endproperty
   a_id_exit: assert property (p_id_exit) else $error("ID mode left without reset");

   property p_hw_reset_pulse;
      @(posedge clk) disable iff (sys_rst)
      $fell(flash_reset_n) |-> !flash_reset_n [*8] ##0 (state == S_HWRST);
   endproperty
   a_hw_reset_pulse: assert property (p_hw_reset_pulse) else $error("reset pulse short");

   property p_ready_done;
      @(posedge clk) disable iff (sys_rst)
      (state == S_WAIT_READY && !ready_busy_n) |=> (!rsp_valid && $stable(mode));
   endproperty
   a_ready_done: assert property (p_ready_done) else $error("done while busy");

   property p_window_end;
      @(posedge clk) disable iff (sys_rst)
      (win_expire && !(state == S_BUS && bus_done)) |=> (mode == M_ERASING);
   endproperty
   a_window_end: assert property (p_window_end) else $error("window did not end");

   property p_suspend_window;
      @(posedge clk) disable iff (sys_rst)
      (state == S_BUS && bus_done && cur.op == OP_SUSPEND && mode == M_WINDOW && !win_expire)
         |=> (mode == M_SUSPENDED && rsp_valid);
   endproperty
   a_suspend_window: assert property (p_suspend_window) else $error("suspend late");

   property p_sector_bits;
      @(posedge clk) disable iff (sys_rst)
      (bus_start && sect_addr_step) |=> (flash_bus.addr[15:0] == 16'h0000) [*8];
   endproperty
   a_sector_bits: assert property (p_sector_bits) else $error("low sector bits set");

   property p_unlock_first;
      @(posedge clk) disable iff (sys_rst)
      (bus_start && step == 3'd0 && cur.op == OP_PROGRAM) |-> ##3 (flash_bus.data_out ==
         FCS_UNLOCK1 && !flash_bus.we_n);
   endproperty
   a_unlock_first: assert property (p_unlock_first) else $error("bad unlock byte");

   c_program: cover property (@(posedge clk) state == S_WAIT_READY ##1 rsp_valid);
   c_window: cover property (@(posedge clk) mode == M_WINDOW ##1 mode == M_ERASING);
   c_suspend: cover property (@(posedge clk) mode == M_ERASING ##1 mode == M_SUSPENDED);
   c_id_read: cover property (@(posedge clk) mode == M_ID && rsp_valid && cur.op == OP_READ);

endmodule : fcs_host

// [logic/fcs_pkg.sv]
package fcs_pkg;

   // Host-side orders accepted at the user port.
   typedef enum logic [3:0] {
      OP_READ, OP_ID_ENTER, OP_RESET, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROGRAM,
      OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND,
      OP_HW_RESET
   } fcs_op_t;

   // Mode of the flash device as the host tracks it.
   typedef enum logic [2:0] {
      M_ARRAY, M_ID, M_BYPASS, M_WINDOW, M_ERASING, M_SUSPENDED
   } fcs_mode_t;

   typedef struct packed {
      fcs_op_t op;
      logic [20:0] addr;
      logic [7:0] data;
   } fcs_req_t;

   // Parallel flash pins; data_oe_n is low while the host drives data_lines.
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [20:0] addr;
      logic [7:0] data_out;
      logic data_oe_n;
   } fcs_bus_t;

   localparam fcs_bus_t FCS_BUS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
      addr: 21'h000000, data_out: 8'h00, data_oe_n: 1'b1};

   // Command bytes.
   localparam logic [7:0] FCS_UNLOCK1 = 8'haa;
   localparam logic [7:0] FCS_UNLOCK2 = 8'h55;
   localparam logic [7:0] FCS_CMD_ID = 8'h90;
   localparam logic [7:0] FCS_CMD_RESET = 8'hf0;
   localparam logic [7:0] FCS_CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] FCS_CMD_BYPASS = 8'h20;
   localparam logic [7:0] FCS_CMD_BYP_EXIT1 = 8'h90;
   localparam logic [7:0] FCS_CMD_BYP_EXIT2 = 8'h00;
   localparam logic [7:0] FCS_CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] FCS_CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] FCS_CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] FCS_CMD_SUSPEND = 8'hb0;

   // Unlock addresses are don't-care to the device; these are fixed values.
   localparam logic [20:0] FCS_UNLOCK_ADDR1 = 21'h000555;
   localparam logic [20:0] FCS_UNLOCK_ADDR2 = 21'h0002aa;
   localparam int unsigned FCS_SECTOR_LSB = 16;

   // Identification read offsets in the low address byte.
   localparam logic [7:0] FCS_ID_MAKER = 8'h00;
   localparam logic [7:0] FCS_ID_PART = 8'h01;
   localparam logic [7:0] FCS_ID_LOCK = 8'h02;

   // Timing, times in their own unit and derived cycle counts at 250 MHz.
   localparam int unsigned FCS_CLK_NS = 4;
   localparam int unsigned FCS_WE_LOW_NS = 35;
   localparam int unsigned FCS_WE_LOW_CYC = (FCS_WE_LOW_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
   localparam int unsigned FCS_READ_ACC_NS = 90;
   localparam int unsigned FCS_READ_CYC = (FCS_READ_ACC_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
   localparam int unsigned FCS_RECOVER_NS = 20;
   localparam int unsigned FCS_RECOVER_CYC = (FCS_RECOVER_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
   localparam int unsigned FCS_BUSY_DLY_NS = 90;
   localparam int unsigned FCS_BUSY_DLY_CYC = (FCS_BUSY_DLY_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
   localparam int unsigned FCS_RST_PULSE_NS = 500;
   localparam int unsigned FCS_RST_PULSE_CYC = (FCS_RST_PULSE_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
   localparam int unsigned FCS_WINDOW_US = 50;
   localparam int unsigned FCS_WINDOW_CYC = FCS_WINDOW_US * 1000 / FCS_CLK_NS;
   localparam int unsigned FCS_SUSPEND_US = 20;
   localparam int unsigned FCS_SUSPEND_CYC = FCS_SUSPEND_US * 1000 / FCS_CLK_NS;
   localparam int unsigned FCS_ADD_GUARD_CYC = 32;

endpackage : fcs_pkg

// [logic/fcs_bus_cycle.sv]
`timescale 1ns/10ps
module fcs_bus_cycle import fcs_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic is_read,
   input wire logic [20:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] data_in,
   output logic done,
   output logic [7:0] rdata,
   output fcs_bus_t bus
);

   typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fcs_bstate_t;

   fcs_bstate_t st;
   logic [5:0] cnt;
   logic rd;

   // One bus cycle: address set up with chip enable first, then a strobe, then recovery.
   // Data stays driven past the strobe's rising edge, where the device takes it.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= B_IDLE;
         cnt <= 6'h00;
         rd <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         bus <= FCS_BUS_IDLE;
      end else begin
         done <= 1'b0;
         unique case (st)
            B_IDLE: begin
               if (start) begin
                  bus.addr <= addr;
                  bus.data_out <= wdata;
                  bus.data_oe_n <= is_read;
                  bus.ce_n <= 1'b0;
                  rd <= is_read;
                  st <= B_SETUP;
               end
            end
            B_SETUP: begin
               bus.we_n <= rd;
               bus.oe_n <= !rd;
               cnt <= rd ? 6'(FCS_READ_CYC - 1) : 6'(FCS_WE_LOW_CYC - 1);
               st <= B_STROBE;
            end
            B_STROBE: begin
               if (cnt == 6'h00) begin
                  bus.we_n <= 1'b1;
                  bus.oe_n <= 1'b1;
                  if (rd) begin
                     rdata <= data_in;
                  end
                  cnt <= 6'(FCS_RECOVER_CYC - 1);
                  st <= B_HOLD;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
            B_HOLD: begin
               if (cnt == 6'h00) begin
                  bus.ce_n <= 1'b1;
                  bus.data_oe_n <= 1'b1;
                  done <= 1'b1;
                  st <= B_IDLE;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
         endcase
      end
   end

   property p_we_width;
      @(posedge clk) disable iff (sys_rst)
      $fell(bus.we_n) |-> !bus.we_n [*8];
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe too short");

   property p_addr_held;
      @(posedge clk) disable iff (sys_rst)
      (!bus.we_n && $past(!bus.we_n)) |-> ($stable(bus.addr) && $stable(bus.data_out));
   endproperty
   a_addr_held: assert property (p_addr_held) else $error("address moved under strobe");

   property p_cycle_len;
      @(posedge clk) disable iff (sys_rst)
      (start && st == B_IDLE) |-> ##[16:30] done;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("bus cycle length wrong");

endmodule : fcs_bus_cycle

// [testbench/fcs_flash_model.sv]
`timescale 1ns/10ps
module fcs_flash_model import fcs_pkg::*; #(
   parameter int unsigned BUSY_CYC = 40,
   parameter int unsigned WIN_CYC = 200,
   parameter logic [7:0] MAKER_CODE = 8'h11, // Arbitrary value.
   parameter logic [7:0] PART_CODE = 8'h22, // Arbitrary value.
   parameter logic [4:0] LOCKED_SECTOR = 5'h01,
   parameter logic [7:0] SUSP_STATUS = 8'h80
) (
   input wire logic clk,
   input wire fcs_bus_t bus,
   input wire logic reset_n,
   output logic [7:0] data_lines,
   output logic ready_busy_n
);
   typedef enum logic [2:0] {S_ARRAY, S_ID, S_BYP, S_WIN, S_ERASE, S_SUSP, S_PROG} fcs_dev_t;
   fcs_dev_t st = S_ARRAY;
   logic [7:0] mem [0:8191] = '{default: 8'hff};
   logic [39:0] h = '0;
   logic [31:0] em = '0;
   logic [20:0] al = '0;
   logic we_q = 1'b1, susp = 1'b0, byp = 1'b0;
   int cnt = 0;
   initial begin
      data_lines = 8'h00;
      ready_busy_n = 1'b1;
   end
   function automatic logic [7:0] rdv(input logic [20:0] a);
      if (st == S_ID) return (a[7:0] == FCS_ID_MAKER) ? MAKER_CODE : (a[7:0] == FCS_ID_PART) ?
         PART_CODE : {7'h00, a[7:0] == FCS_ID_LOCK && a[20:16] == LOCKED_SECTOR};
      if (st == S_SUSP && em[a[20:16]]) return SUSP_STATUS;
      return mem[{a[20:16], a[7:0]}];
   endfunction : rdv
   task automatic fin();
      if (st == S_WIN) begin
         st = S_ERASE;
         cnt = BUSY_CYC;
      end else if (st inside {S_PROG, S_ERASE}) begin
         if (st == S_ERASE) for (int i = 0; i < 8192; i++) if (em[i[12:8]]) mem[i] = 8'hff;
         st = susp ? S_SUSP : byp ? S_BYP : S_ARRAY;
      end
   endtask : fin
   task automatic wr(input logic [7:0] d);
      logic [12:0] ix;
      ix = {al[20:16], al[7:0]};
      case (st)
         S_PROG: ;
         S_ERASE: if (d == FCS_CMD_SUSPEND) st = S_SUSP;
         S_WIN: if (d == FCS_CMD_SECTOR_ERASE) begin
            em[al[20:16]] = 1'b1;
            cnt = WIN_CYC;
         end else st = (d == FCS_CMD_SUSPEND) ? S_SUSP : S_ARRAY;
         S_BYP: begin
            if (h[7:0] == FCS_CMD_PROGRAM) begin
               mem[ix] = mem[ix] & d;
               st = S_PROG;
               cnt = BUSY_CYC;
            end else if (h[7:0] == FCS_CMD_BYP_EXIT1 && d == FCS_CMD_BYP_EXIT2) begin
               st = S_ARRAY;
               byp = 1'b0;
            end
            h = (h == '0 && d inside {FCS_CMD_PROGRAM, FCS_CMD_BYP_EXIT1}) ? {32'h0, d} : '0;
         end
         default: begin
            if (d == FCS_CMD_RESET && h[23:0] != 24'haa55a0) st = susp ? S_SUSP : S_ARRAY;
            else if (h[23:0] == 24'haa55a0) begin
               mem[ix] = mem[ix] & d;
               st = S_PROG;
               cnt = BUSY_CYC;
            end else if (h[15:0] == 16'haa55 && d == FCS_CMD_ID) st = S_ID;
            else if (st == S_ARRAY && h[15:0] == 16'haa55 && d == FCS_CMD_BYPASS) begin
               st = S_BYP;
               byp = 1'b1;
            end else if (st == S_ARRAY && h == 40'haa5580aa55 && d == FCS_CMD_CHIP_ERASE) begin
               mem = '{default: 8'hff};
               st = S_PROG;
               cnt = BUSY_CYC;
            end else if (st == S_ARRAY && h == 40'haa5580aa55 && d == FCS_CMD_SECTOR_ERASE) begin
               em = '0;
               em[al[20:16]] = 1'b1;
               st = S_WIN;
               cnt = WIN_CYC;
            end else begin
               h = (d == FCS_UNLOCK1 || h != '0) ? {h[31:0], d} : '0;
               return;
            end
            h = '0;
         end
      endcase
   endtask : wr
   // Outputs are registered so the host never samples them mid-update; idle lines toggle.
   always @(posedge clk) begin
      if (!reset_n) begin
         st = S_ARRAY;
         susp = 1'b0;
         byp = 1'b0;
         h = '0;
         cnt = 0;
      end else begin
         if (cnt == 1) fin();
         if (cnt > 0) cnt--;
         if (we_q && !bus.we_n) al = bus.addr;
         if (!we_q && bus.we_n && !bus.ce_n) wr(bus.data_out);
      end
      if (st == S_SUSP) susp = 1'b1;
      we_q = bus.we_n;
      ready_busy_n <= !(st inside {S_PROG, S_ERASE, S_WIN});
      data_lines <= (!bus.ce_n && !bus.oe_n) ? rdv(bus.addr) : ~data_lines;
   end
endmodule : fcs_flash_model

// [testbench/flash_command_sequencer_tb_top.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module flash_command_sequencer_tb_top import fcs_pkg::*;;
   localparam logic [7:0] MK = 8'h5a; // Arbitrary value.
   localparam logic [7:0] PT = 8'h3c; // Arbitrary value.
   logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, rdy, rv, re, frn, rbn;
   logic [7:0] rd, dl;
   fcs_req_t req = '0;
   fcs_mode_t mode;
   fcs_bus_t fb;
   int err_count = 0, cmp_count = 0, tick = 0;
   fcs_host #(.WINDOW_CYC(200), .SUSPEND_CYC(50)) uut (.clk(clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req(req), .req_ready(rdy), .rsp_valid(rv), .rsp_data(rd),
      .rsp_error(re), .mode(mode), .flash_bus(fb), .flash_reset_n(frn), .data_lines_in(dl),
      .ready_busy_n(rbn));
   fcs_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT), .WIN_CYC(200)) dev (.clk(clk),
      .bus(fb), .reset_n(frn), .data_lines(dl), .ready_busy_n(rbn));
   initial forever #2 clk = ~clk;
   // A hung handshake ends the run well past the few thousand cycles needed.
   always @(posedge clk) begin
      tick++;
      if (tick == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic op(input fcs_op_t o, input logic [20:0] a, input logic [7:0] d);
      @(posedge clk); // An edge passes so req_valid never drops and rises in one step.
      #1 req = '{op: o, addr: a, data: d};
      req_valid = 1'b1;
      while (rdy !== 1'b1) begin @(posedge clk); #1; end
      @(posedge clk);
      #1 req_valid = 1'b0;
      while (rv !== 1'b1) begin @(posedge clk); #1; end
   endtask : op
   task automatic md(input fcs_mode_t m);
      @(posedge clk);
      #1 `CHK("mode", m, mode)
   endtask : md
   task automatic t_id();
      op(OP_ID_ENTER, 21'h000000, 8'h00); md(M_ID);
      op(OP_READ, 21'h1f0000, 8'h00); `CHK("maker", MK, rd)
      op(OP_READ, 21'h0a0001, 8'h00); `CHK("part", PT, rd)
      op(OP_READ, 21'h010002, 8'h00); `CHK("locked", 8'h01, rd)
      op(OP_READ, 21'h020002, 8'h00); `CHK("open", 8'h00, rd)
      op(OP_PROGRAM, 21'h000000, 8'h00); `CHK("id refuse", 1'b1, re)
      op(OP_RESET, 21'h000000, 8'h00); md(M_ARRAY);
   endtask : t_id
   task automatic t_prog();
      op(OP_PROGRAM, 21'h030012, 8'h5a); `CHK("prog err", 1'b0, re)
      op(OP_READ, 21'h030012, 8'h00); `CHK("prog", 8'h5a, rd)
      op(OP_PROGRAM, 21'h030012, 8'hff);
      op(OP_READ, 21'h030012, 8'h00); `CHK("no rise", 8'h5a, rd)
   endtask : t_prog
   task automatic t_byp();
      op(OP_BYP_ENTER, 21'h000000, 8'h00); md(M_BYPASS);
      op(OP_BYP_PROGRAM, 21'h040001, 8'h81);
      op(OP_BYP_PROGRAM, 21'h040002, 8'h7e);
      op(OP_READ, 21'h040002, 8'h00); `CHK("byp refuse", 1'b1, re)
      op(OP_BYP_EXIT, 21'h000000, 8'h00); md(M_ARRAY);
      op(OP_READ, 21'h040002, 8'h00); `CHK("byp prog", 8'h7e, rd)
   endtask : t_byp
   task automatic t_chip();
      op(OP_SUSPEND, 21'h000000, 8'h00); `CHK("susp refuse", 1'b1, re)
      op(OP_CHIP_ERASE, 21'h000000, 8'h00);
      op(OP_READ, 21'h030012, 8'h00); `CHK("chip", 8'hff, rd)
      // A second erase is cut by the hardware reset while the host waits on busy.
      req = '{op: OP_CHIP_ERASE, addr: 21'h000000, data: 8'h00};
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      while (rbn !== 1'b0) begin @(posedge clk); #1; end
      op(OP_HW_RESET, 21'h000000, 8'h00); `CHK("abort", 1'b0, re)
      md(M_ARRAY);
   endtask : t_chip
   task automatic t_sect();
      op(OP_PROGRAM, 21'h050010, 8'h00);
      op(OP_PROGRAM, 21'h060010, 8'h00);
      op(OP_PROGRAM, 21'h070010, 8'h00);
      op(OP_SECTOR_ERASE, 21'h05abcd, 8'h00);
      op(OP_SECTOR_ADD, 21'h06ffff, 8'h00);
      while (mode !== M_ARRAY) begin @(posedge clk); #1; end
      op(OP_READ, 21'h050010, 8'h00); `CHK("sect a", 8'hff, rd)
      op(OP_READ, 21'h060010, 8'h00); `CHK("sect b", 8'hff, rd)
      op(OP_READ, 21'h070010, 8'h00); `CHK("sect kept", 8'h00, rd)
   endtask : t_sect
   task automatic t_susp();
      op(OP_SECTOR_ERASE, 21'h070000, 8'h00);
      op(OP_SUSPEND, 21'h000000, 8'h00); md(M_SUSPENDED);
      op(OP_READ, 21'h070010, 8'h00); `CHK("status", 8'h80, rd)
      op(OP_PROGRAM, 21'h020005, 8'h3c);
      op(OP_READ, 21'h020005, 8'h00); `CHK("susp prog", 8'h3c, rd)
      op(OP_HW_RESET, 21'h000000, 8'h00); md(M_ARRAY);
   endtask : t_susp
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // Reset is held for four edges, then each scenario runs in turn.
   initial begin
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      t_id();
      t_prog();
      t_byp();
      t_chip();
      t_sect();
      t_susp();
      report_and_stop();
   end
endmodule : flash_command_sequencer_tb_top
